// ==== design/ogrb_bank.v ====
// Output gating register bank with per-output divider and enable gating
`timescale 1ns/1ps
// Behaviour
// - Readiness byte reads 0x0F when ready, 0xF3 while not ready.
// - Readiness byte readable at offset 0xFE on every page.
// - Global gate bit 0 low disables all outputs; reset value low.
// - External enable pin high disables all outputs regardless of bits.
// - Powerdown bit 0 high puts driver pins high impedance.
// - Per-output enable bit 1 low disables that output; reset low.
// - Force bit 2 high makes divider divide by 2, ignoring value.
// - Divider value zero alone does not select divide by 2.
// - Bypass bit 3 removes final halving stage; duty follows upstream.
// - Format field 2:0 selects differential or single-ended pin use.
// - Format bit 3 picks asynchronous or glitchless enable changes.
// - Disabled-level field 5:4 holds disabled output low or high.
// - 29-bit extension timer over four bytes, low byte first.
`include "ogrb_defines.vh"

module ogrb_bank #(
    parameter NOUT = 1,
    parameter DIVW = 8,
    parameter READY_CYCLES = (`OGRB_READY_NS + `OGRB_CLK_NS - 1) / `OGRB_CLK_NS
) (
    input wire mclk,
    input wire rstn,
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    output reg reg_rvalid,
    input wire nvm_busy,
    input wire ext_output_enable_n,
    input wire src_tick,
    input wire [NOUT*DIVW-1:0] output_divider_value,
    output wire [28:0] loopb_bandwidth_switch_extend,
    output reg [NOUT-1:0] out_true,
    output reg [NOUT-1:0] out_comp,
    output reg [NOUT-1:0] out_true_oe_n,
    output reg [NOUT-1:0] out_comp_oe_n
);

    reg [7:0] page_reg;
    reg [7:0] ext0_reg;
    reg [7:0] ext1_reg;
    reg [7:0] ext2_reg;
    reg [7:0] ext3_reg;
    reg [7:0] gate_reg;
    reg [15:0] ready_cnt_reg;
    reg ready_reg;
    reg oe_pin_meta_reg;
    reg oe_pin_reg;
    reg [7:0] rdata_next;
    wire [15:0] full_addr;
    wire wr_ok;
    wire [NOUT*8-1:0] ctl_all;
    wire [NOUT*8-1:0] fmt_all;
    wire [7:0] ready_byte;
    integer k;

    assign full_addr = {page_reg, reg_addr};
    // Writes are dropped until the bank is ready; the host should poll
    assign wr_ok = reg_wr & ready_reg;
    assign ready_byte = ready_reg ? `OGRB_READY_CODE
                                  : `OGRB_BUSY_CODE;
    // Top byte only holds five timer bits
    assign loopb_bandwidth_switch_extend =
        {ext3_reg[4:0], ext2_reg, ext1_reg, ext0_reg};

    // Pin enable crosses in from a board pin: two flops first
    always @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            oe_pin_meta_reg <= 1'b1;
            oe_pin_reg <= 1'b1;
        end
        else
        begin
            oe_pin_meta_reg <= ext_output_enable_n;
            oe_pin_reg <= oe_pin_meta_reg;
        end
    end

    // Start-up counter; an NVM write in progress also reads as busy
    always @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            ready_cnt_reg <= 16'h0000;
            ready_reg <= 1'b0;
        end
        else
        begin
            if (ready_cnt_reg != READY_CYCLES[15:0])
                ready_cnt_reg <= ready_cnt_reg + 16'h0001;
            ready_reg <= (ready_cnt_reg == READY_CYCLES[15:0])
                         & ~nvm_busy;
        end
    end

    // Shared registers: page select, timer bytes, global gate
    always @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            page_reg <= `OGRB_RST_PAGE;
            ext0_reg <= `OGRB_RST_BYTE;
            ext1_reg <= `OGRB_RST_BYTE;
            ext2_reg <= `OGRB_RST_BYTE;
            ext3_reg <= `OGRB_RST_BYTE;
            gate_reg <= `OGRB_RST_BYTE;
        end
        else if (wr_ok)
        begin
            // Page select sits at the same offset on every page
            if (reg_addr == `OGRB_OFS_PAGE)
                page_reg <= reg_wdata;
            if (full_addr == `OGRB_ADDR_EXT0)
                ext0_reg <= reg_wdata;
            if (full_addr == `OGRB_ADDR_EXT1)
                ext1_reg <= reg_wdata;
            if (full_addr == `OGRB_ADDR_EXT2)
                ext2_reg <= reg_wdata;
            if (full_addr == `OGRB_ADDR_EXT3)
                ext3_reg <= reg_wdata & `OGRB_EXT3_MASK;
            if (full_addr == `OGRB_ADDR_GATE)
                gate_reg <= {7'h00, reg_wdata[`OGRB_GATE_BIT]};
        end
    end

    // Read decode; unmapped addresses read as zero
    always @*
    begin
        rdata_next = 8'h00;
        if (reg_addr == `OGRB_OFS_READY)
            rdata_next = ready_byte;
        else if (reg_addr == `OGRB_OFS_PAGE)
            rdata_next = page_reg;
        else if (full_addr == `OGRB_ADDR_EXT0)
            rdata_next = ext0_reg;
        else if (full_addr == `OGRB_ADDR_EXT1)
            rdata_next = ext1_reg;
        else if (full_addr == `OGRB_ADDR_EXT2)
            rdata_next = ext2_reg;
        else if (full_addr == `OGRB_ADDR_EXT3)
            rdata_next = ext3_reg;
        else if (full_addr == `OGRB_ADDR_GATE)
            rdata_next = gate_reg;
        else
        begin
            for (k = 0; k < NOUT; k = k + 1)
            begin
                if (full_addr == `OGRB_ADDR_OUT0_CTL
                                 + k * `OGRB_OUT_STRIDE)
                    rdata_next = ctl_all[k*8 +: 8];
                if (full_addr == `OGRB_ADDR_OUT0_FMT
                                 + k * `OGRB_OUT_STRIDE)
                    rdata_next = fmt_all[k*8 +: 8];
            end
        end
    end

    // Read answer one cycle after the strobe
    always @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rvalid <= reg_rd;
            if (reg_rd)
                reg_rdata <= rdata_next;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NOUT; gi = gi + 1)
        begin : g_out
            localparam [31:0] CTL32 = `OGRB_ADDR_OUT0_CTL
                                      + gi * `OGRB_OUT_STRIDE;
            localparam [31:0] FMT32 = `OGRB_ADDR_OUT0_FMT
                                      + gi * `OGRB_OUT_STRIDE;
            reg [7:0] ctl_reg;
            reg [7:0] fmt_reg;
            reg [DIVW:0] cnt_reg;
            reg half_reg;
            reg pulse_reg;
            reg active_reg;
            reg true_next;
            reg comp_next;
            reg true_oe_n_next;
            reg comp_oe_n_next;
            wire [DIVW:0] lim;
            wire force_half;
            wire bypass;
            wire pdn;
            wire want;
            wire rpulse;
            wire raw_clk;
            wire dis_lvl;
            wire [2:0] fmt;

            assign ctl_all[gi*8 +: 8] = ctl_reg;
            assign fmt_all[gi*8 +: 8] = fmt_reg;
            assign pdn = ctl_reg[`OGRB_PDN_BIT];
            assign force_half = ctl_reg[`OGRB_FORCE_BIT];
            assign bypass = ctl_reg[`OGRB_BYP_BIT];
            assign fmt = fmt_reg[`OGRB_FMT_MSB:`OGRB_FMT_LSB];
            // Reserved level codes fall back to low
            assign dis_lvl = (fmt_reg[`OGRB_DIS_MSB:`OGRB_DIS_LSB]
                              == `OGRB_DIS_HIGH);
            // Unforced stage spans value+2 ticks, so zero is never a halve
            assign lim = {1'b0, output_divider_value[gi*DIVW +: DIVW]}
                         + {{DIVW{1'b0}}, 1'b1};
            assign rpulse = src_tick & (force_half
                            | (cnt_reg == lim));
            // Bypass hands the stage pulse straight out
            assign raw_clk = bypass ? pulse_reg : half_reg;
            assign want = gate_reg[`OGRB_GATE_BIT] & ~oe_pin_reg
                          & ctl_reg[`OGRB_EN_BIT]
                          & ~pdn;

            // Per-output control and format registers
            always @(posedge mclk or negedge rstn)
            begin
                if (!rstn)
                begin
                    ctl_reg <= `OGRB_RST_BYTE;
                    fmt_reg <= `OGRB_RST_BYTE;
                end
                else if (wr_ok)
                begin
                    if (full_addr == CTL32[15:0])
                        ctl_reg <= {4'h0, reg_wdata[3:0]};
                    if (full_addr == FMT32[15:0])
                        fmt_reg <= reg_wdata;
                end
            end

            // Divider stage and final halving stage
            always @(posedge mclk or negedge rstn)
            begin
                if (!rstn)
                begin
                    cnt_reg <= {(DIVW+1){1'b0}};
                    half_reg <= 1'b0;
                    pulse_reg <= 1'b0;
                end
                else
                begin
                    pulse_reg <= rpulse;
                    if (rpulse)
                    begin
                        cnt_reg <= {(DIVW+1){1'b0}};
                        half_reg <= ~half_reg;
                    end
                    else if (src_tick)
                        cnt_reg <= cnt_reg + {{DIVW{1'b0}}, 1'b1};
                end
            end

            // Glitchless mode opens only when the clock rests at the idle level; it closes at once
            always @(posedge mclk or negedge rstn)
            begin
                if (!rstn)
                    active_reg <= 1'b0;
                else if (!fmt_reg[`OGRB_SYNC_BIT])
                    active_reg <= want;
                else if (!want || raw_clk == dis_lvl)
                    active_reg <= want;
            end

            // Pin drive by format; enables are active low
            always @*
            begin
                true_next = dis_lvl;
                comp_next = ~dis_lvl;
                true_oe_n_next = 1'b0;
                comp_oe_n_next = 1'b0;
                if (active_reg)
                begin
                    true_next = raw_clk;
                    comp_next = ~raw_clk;
                end
                case (fmt)
                    `OGRB_FMT_DIFF, `OGRB_FMT_DIFF_LP:
                    begin
                        true_oe_n_next = 1'b0;
                    end
                    `OGRB_FMT_SE_BOTH:
                    begin
                        comp_next = true_next;
                    end
                    `OGRB_FMT_SE_TRUE:
                    begin
                        comp_oe_n_next = 1'b1;
                    end
                    `OGRB_FMT_SE_COMP:
                    begin
                        comp_next = true_next;
                        true_oe_n_next = 1'b1;
                    end
                    default:
                    begin
                        // Reserved formats leave both pins floating
                        true_oe_n_next = 1'b1;
                        comp_oe_n_next = 1'b1;
                    end
                endcase
                if (pdn)
                begin
                    true_next = 1'b0;
                    comp_next = 1'b0;
                    true_oe_n_next = 1'b1;
                    comp_oe_n_next = 1'b1;
                end
            end

            // Registered pin outputs
            always @(posedge mclk or negedge rstn)
            begin
                if (!rstn)
                begin
                    out_true[gi] <= 1'b0;
                    out_comp[gi] <= 1'b0;
                    out_true_oe_n[gi] <= 1'b1;
                    out_comp_oe_n[gi] <= 1'b1;
                end
                else
                begin
                    out_true[gi] <= true_next;
                    out_comp[gi] <= comp_next;
                    out_true_oe_n[gi] <= true_oe_n_next;
                    out_comp_oe_n[gi] <= comp_oe_n_next;
                end
            end
        end
    endgenerate

endmodule

// ==== design/ogrb_defines.vh ====
// Register offsets, field positions and reset values of the gating bank
`ifndef OGRB_DEFINES_VH
`define OGRB_DEFINES_VH

// In-page register offsets
`define OGRB_OFS_PAGE 8'h01
`define OGRB_OFS_READY 8'hFE

// Full addresses {page, offset}
`define OGRB_ADDR_EXT0 16'h00EA
`define OGRB_ADDR_EXT1 16'h00EB
`define OGRB_ADDR_EXT2 16'h00EC
`define OGRB_ADDR_EXT3 16'h00ED
`define OGRB_ADDR_GATE 16'h0102
`define OGRB_ADDR_OUT0_CTL 16'h0103
`define OGRB_ADDR_OUT0_FMT 16'h0104
`define OGRB_OUT_STRIDE 16'h0005

// Readiness codes
`define OGRB_READY_CODE 8'h0F
`define OGRB_BUSY_CODE 8'hF3

// Gate, control and format register fields and timer top-byte mask
`define OGRB_GATE_BIT 0
`define OGRB_PDN_BIT 0
`define OGRB_EN_BIT 1
`define OGRB_FORCE_BIT 2
`define OGRB_BYP_BIT 3
`define OGRB_FMT_LSB 0
`define OGRB_FMT_MSB 2
`define OGRB_SYNC_BIT 3
`define OGRB_DIS_LSB 4
`define OGRB_DIS_MSB 5
`define OGRB_EXT3_MASK 8'h1F

// Format and disabled-level codes
`define OGRB_FMT_DIFF 3'h1
`define OGRB_FMT_DIFF_LP 3'h2
`define OGRB_FMT_SE_BOTH 3'h4
`define OGRB_FMT_SE_TRUE 3'h5
`define OGRB_FMT_SE_COMP 3'h6
`define OGRB_DIS_HIGH 2'h1

// Reset values
`define OGRB_RST_BYTE 8'h00
`define OGRB_RST_PAGE 8'h00

// Start-up time before the bank accepts writes and clock period, in ns
`define OGRB_READY_NS 100
`define OGRB_CLK_NS 5

`endif

// ==== verif/ogrb_host.sv ====
// Host model for the byte register port of the gating bank
`timescale 1ns/1ps
module ogrb_host (
    input wire mclk,
    output reg [7:0] reg_addr,
    output reg reg_wr,
    output reg reg_rd,
    output reg [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire reg_rvalid
);
    reg [7:0] page_reg = 8'h00;
    reg [7:0] q = 8'h00;
    reg qv = 1'b0;
    initial
    begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end
    // One strobe cycle; released lines show the inverse, not stale data
    task cyc(input [7:0] a, input [7:0] d, input w);
    begin
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
        // Answer stands for the cycle after the strobe edge
        @(posedge mclk);
        q = reg_rdata;
        qv = reg_rvalid;
    end
    endtask
    // Full address access; page select rewritten only on change
    task acc(input [15:0] a, input [7:0] d, input w);
    begin
        if (a[15:8] != page_reg)
            cyc(8'h01, a[15:8], 1'b1);
        page_reg = a[15:8];
        cyc(a[7:0], d, w);
    end
    endtask
endmodule

// ==== verif/ogrb_bank_properties.sv ====
// Port assertions of the output gating register bank
`timescale 1ns/1ps
module ogrb_bank_props #(
    parameter NOUT = 1,
    parameter DIVW = 8
) (
    input wire mclk,
    input wire rstn,
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire reg_rvalid,
    input wire nvm_busy,
    input wire ext_output_enable_n,
    input wire src_tick,
    input wire [28:0] loopb_bandwidth_switch_extend,
    input wire [NOUT-1:0] out_true,
    input wire [NOUT-1:0] out_comp
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    // Long enough to cover the pin sync plus the pin flop
    sequence pin_off_s;
        (ext_output_enable_n && !reg_wr)[*8];
    endsequence
    sequence quiet_s;
        (!src_tick && !reg_wr && $stable(ext_output_enable_n))[*8];
    endsequence
    sequence busy_poll_s;
        nvm_busy ##1 (nvm_busy && reg_rd && reg_addr == 8'hFE);
    endsequence
    AST_RVALID: assert property (reg_rd |=> reg_rvalid)
        else $error("read gave no valid");
    AST_NO_RVALID: assert property (!reg_rd |=> !reg_rvalid)
        else $error("valid without read");
    AST_READY_CODE: assert property (reg_rd && reg_addr == 8'hFE |=>
        reg_rdata == 8'h0F || reg_rdata == 8'hF3)
        else $error("bad readiness code");
    AST_BUSY_CODE: assert property (busy_poll_s |=> reg_rdata == 8'hF3)
        else $error("ready while busy");
    AST_RDATA_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved");
    AST_PIN_OFF: assert property (pin_off_s |-> $stable(out_true)
        && $stable(out_comp))
        else $error("output moved with pin high");
    AST_QUIET: assert property (quiet_s |-> $stable(out_true))
        else $error("output moved without source");
    AST_TIMER_RESET: assert property ($rose(rstn) |->
        loopb_bandwidth_switch_extend == 29'h0000000)
        else $error("timer not cleared");
    AST_TIMER_HOLD: assert property (!reg_wr |=>
        $stable(loopb_bandwidth_switch_extend))
        else $error("timer moved without write");
endmodule

bind ogrb_bank ogrb_bank_props #(.NOUT(NOUT), .DIVW(DIVW)) u_props (
    .mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .nvm_busy(nvm_busy), .ext_output_enable_n(ext_output_enable_n),
    .src_tick(src_tick),
    .loopb_bandwidth_switch_extend(loopb_bandwidth_switch_extend),
    .out_true(out_true), .out_comp(out_comp)
);

// ==== verif/tb_top.sv ====
// Self-checking bench of the output gating register bank
`timescale 1ns/1ps
module tb_top;
    reg mclk;
    reg rstn;
    reg nvm_busy;
    reg ext_output_enable_n;
    reg src_tick;
    reg [7:0] divider;
    wire [7:0] reg_addr;
    wire reg_wr;
    wire reg_rd;
    wire [7:0] reg_wdata;
    wire [7:0] reg_rdata;
    wire reg_rvalid;
    wire [28:0] timer;
    wire out_true;
    wire out_true_oe_n;
    wire out_comp;
    wire out_comp_oe_n;
    integer num_errors = 0;
    integer num_checks = 0;
    integer tog = 0;
    integer tog0 = 0;
    integer i;
    reg prev = 1'b0;
    reg [35:0] r;
    // Address, byte written, byte read back
    reg [31:0] reg_rows [0:9];
    // Ctl, fmt, gate, pin, divider, toggles, oe_n, level
    reg [35:0] out_rows [0:7];
    // Short start-up count keeps the run brief
    ogrb_bank #(.READY_CYCLES(2)) uut (
        .mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .nvm_busy(nvm_busy),
        .ext_output_enable_n(ext_output_enable_n), .src_tick(src_tick),
        .output_divider_value(divider),
        .loopb_bandwidth_switch_extend(timer), .out_true(out_true),
        .out_comp(out_comp), .out_true_oe_n(out_true_oe_n),
        .out_comp_oe_n(out_comp_oe_n)
    );
    ogrb_host host (
        .mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid)
    );
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // Count pin edges seen at each clock
    always @(posedge mclk)
    begin
        if (out_true !== prev)
            tog = tog + 1;
        prev = out_true;
    end
    task chk(input [8*8-1:0] nm, input [28:0] seen, input [28:0] exp);
    begin
        num_checks = num_checks + 1;
        if (seen !== exp)
        begin
            num_errors = num_errors + 1;
            $display("BAD %0s exp %h seen %h", nm, exp, seen);
        end
    end
    endtask
    task test_done;
    begin
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
    endtask
    // Polls without touching page select, as a reader must
    task poll;
        integer n;
    begin
        for (n = 0; n == 0 || (n < 50 && host.q !== 8'h0F); n = n + 1)
            host.cyc(8'hFE, 8'h00, 1'b0);
        chk("ready", 29'(host.q), 29'h000000F);
    end
    endtask
    // Spaced source pulses, then time for the pins to settle
    task ticks(input integer n);
        integer k;
    begin
        for (k = 0; k < n; k = k + 1)
        begin
            @(posedge mclk);
            src_tick <= 1'b1;
            @(posedge mclk);
            src_tick <= 1'b0;
            repeat (2) @(posedge mclk);
        end
        repeat (8) @(posedge mclk);
    end
    endtask
    initial
    begin
        #100000;
        num_errors = num_errors + 1;
        test_done;
    end
    initial
    begin
        rstn = 1'b0;
        nvm_busy = 1'b0;
        ext_output_enable_n = 1'b0;
        src_tick = 1'b0;
        divider = 8'h00;
        reg_rows[0] = {16'h00EA, 8'hA5, 8'hA5};
        reg_rows[1] = {16'h00EB, 8'h5A, 8'h5A};
        reg_rows[2] = {16'h00EC, 8'hC3, 8'hC3};
        reg_rows[3] = {16'h00ED, 8'hFF, 8'h1F};
        reg_rows[4] = {16'h00FE, 8'h00, 8'h0F};
        reg_rows[5] = {16'h0102, 8'hFF, 8'h01};
        reg_rows[6] = {16'h0103, 8'hFF, 8'h0F};
        reg_rows[7] = {16'h0104, 8'h3F, 8'h3F};
        reg_rows[8] = {16'h01FE, 8'h00, 8'h0F};
        reg_rows[9] = {16'h0150, 8'h77, 8'h00};
        out_rows[0] = {8'h06, 8'h01, 2'h2, 8'h05, 8'h0C, 2'h0};
        out_rows[1] = {8'h02, 8'h01, 2'h2, 8'h00, 8'h06, 2'h0};
        out_rows[2] = {8'h0E, 8'h01, 2'h2, 8'h00, 8'h18, 2'h0};
        out_rows[3] = {8'h06, 8'h01, 2'h3, 8'h00, 8'h00, 2'h0};
        out_rows[4] = {8'h06, 8'h11, 2'h0, 8'h00, 8'h00, 2'h1};
        out_rows[5] = {8'h04, 8'h01, 2'h2, 8'h00, 8'h00, 2'h0};
        out_rows[6] = {8'h07, 8'h01, 2'h2, 8'h00, 8'h00, 2'h2};
        // Reserved format releases both pins; the clock still runs beneath
        out_rows[7] = {8'h06, 8'h03, 2'h2, 8'h00, 8'h0C, 2'h2};
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        host.cyc(8'hFE, 8'h00, 1'b0);
        chk("busy", 29'(host.q), 29'h00000F3);
        poll;
        for (i = 0; i < 10; i = i + 1)
        begin
            host.acc(reg_rows[i][31:16], reg_rows[i][15:8], 1'b1);
            host.acc(reg_rows[i][31:16], 8'h00, 1'b0);
            chk("rdback", 29'(host.q), 29'(reg_rows[i][7:0]));
            chk("rvalid", 29'(host.qv), 29'h0000001);
        end
        chk("timer", timer, 29'h1FC35AA5);
        $display("done: registers");
        for (i = 0; i < 8; i = i + 1)
        begin
            r = out_rows[i];
            @(posedge mclk);
            ext_output_enable_n <= r[18];
            divider <= r[17:10];
            host.acc(16'h0102, {7'h00, r[19]}, 1'b1);
            host.acc(16'h0103, r[35:28], 1'b1);
            host.acc(16'h0104, r[27:20], 1'b1);
            repeat (8) @(posedge mclk);
            tog0 = tog;
            ticks(12);
            chk("toggles", 29'(tog - tog0), 29'(r[9:2]));
            chk("oe_n", 29'(out_true_oe_n), 29'(r[1]));
            chk("comp_oe", 29'(out_comp_oe_n), 29'(r[1]));
            if (r[9:2] == 8'h00 && !r[1])
            begin
                chk("level", 29'(out_true), 29'(r[0]));
                chk("comp", 29'(out_comp), 29'(!r[0]));
            end
        end
        $display("done: outputs");
        // Single-ended formats idle high with the unused pin released
        host.acc(16'h0103, 8'h00, 1'b1);
        for (i = 4; i < 7; i = i + 1)
        begin
            host.acc(16'h0104, {4'h1, 1'b0, i[2:0]}, 1'b1);
            repeat (4) @(posedge mclk);
            chk("t_oe", 29'(out_true_oe_n), 29'(i == 6));
            chk("c_oe", 29'(out_comp_oe_n), 29'(i == 5));
            chk("lvl", 29'(i == 6 ? out_comp : out_true), 29'h1);
        end
        // Glitchless enable opens only at the idle level, so without ticks
        // the pin must rest at the disabled level for either level code
        for (i = 0; i < 2; i = i + 1)
        begin
            host.acc(16'h0103, 8'h04, 1'b1);
            host.acc(16'h0104, {3'h0, i[0], 4'h9}, 1'b1);
            host.acc(16'h0103, 8'h06, 1'b1);
            repeat (8) @(posedge mclk);
            chk("glitch", 29'(out_true), 29'(i[0]));
        end
        $display("done: formats and glitchless");
        // Back to page 0 while ready: page writes are dropped when busy
        host.acc(16'h00EA, 8'h00, 1'b0);
        chk("ext0", 29'(host.q), 29'h00000A5);
        @(posedge mclk);
        nvm_busy <= 1'b1;
        host.acc(16'h00FE, 8'h00, 1'b0);
        chk("nvm", 29'(host.q), 29'h00000F3);
        host.acc(16'h00EA, 8'h11, 1'b1);
        @(posedge mclk);
        nvm_busy <= 1'b0;
        host.acc(16'h00EA, 8'h00, 1'b0);
        chk("dropped", 29'(host.q), 29'h00000A5);
        @(posedge mclk);
        rstn <= 1'b0;
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        poll;
        host.acc(16'h0102, 8'h00, 1'b0);
        chk("gate", 29'(host.q), 29'h0000000);
        chk("timer0", timer, 29'h0000000);
        $display("done: busy and reset");
        test_done;
    end
endmodule
